// ---- pkg/prp_defines.svh ----
`ifndef PRP_DEFINES_SVH
`define PRP_DEFINES_SVH

// ****************
// packet kinds and completion status
// ****************
`define PRP_KIND_MRD      3'h0
`define PRP_KIND_MWR      3'h1
`define PRP_KIND_CFGRD    3'h2
`define PRP_KIND_CFGWR    3'h3
`define PRP_KIND_CPL      3'h4
`define PRP_KIND_CPLD     3'h5
`define PRP_ST_SC         3'h0
`define PRP_ST_UR         3'h1
`define PRP_ST_CRS        3'h2

// ****************
// address layout
// ****************
`define PRP_ADDR_HI       63
`define PRP_ADDR_LIM_LO   36
`define PRP_ADDR_LIM_W    28
`define PRP_CFG_REG_HI    11
`define PRP_CFG_FN_HI     27
`define PRP_CFG_FN_LO     12
`define PRP_CFG_EXT_BASE  12'h100

// ****************
// link training
// ****************
`define PRP_RATE_2G5      2'h0
`define PRP_RATE_5G0      2'h1
`define PRP_RATE_8G0      2'h2
`define PRP_WID_X1        5'h01
`define PRP_WID_X2        5'h02
`define PRP_WID_X4        5'h04
`define PRP_WID_X8        5'h08
`define PRP_WID_X16       5'h10
`define PRP_ENC_8B10B     1'h0
`define PRP_ENC_128B130B  1'h1
`define PRP_ST_DETECT     2'h0
`define PRP_ST_NEGOT      2'h1
`define PRP_ST_UP         2'h3
`define PRP_REFCLK_MHZ    100
`define PRP_RETRY_LIMIT   8'h08

`endif

// ---- pkg/prp_pkg.sv ----
`include "prp_defines.svh"

package prp_pkg;

    typedef struct packed {
        logic [2:0]  kind;
        logic [63:0] addr;
        logic [31:0] data;
        logic [7:0]  tag;
        logic [2:0]  status;
        logic        legacy;
    } prp_pkt_t;

    typedef enum logic [1:0] {
        PRP_DETECT = `PRP_ST_DETECT,
        PRP_NEGOT  = `PRP_ST_NEGOT,
        PRP_UP     = `PRP_ST_UP
    } prp_train_t;

    function automatic logic [4:0] prp_pick_width(input logic [4:0] a, input logic [4:0] b);
        logic [4:0] m;
        m = (a < b) ? a : b;
        if (m >= `PRP_WID_X16)
            return `PRP_WID_X16;
        else if (m >= `PRP_WID_X8)
            return `PRP_WID_X8;
        else if (m >= `PRP_WID_X4)
            return `PRP_WID_X4;
        else if (m >= `PRP_WID_X2)
            return `PRP_WID_X2;
        else
            return `PRP_WID_X1;
    endfunction : prp_pick_width

    function automatic logic [1:0] prp_pick_rate(input logic [1:0] a, input logic [1:0] b);
        logic [1:0] m;
        m = (a < b) ? a : b;
        return (m > `PRP_RATE_8G0) ? `PRP_RATE_8G0 : m;
    endfunction : prp_pick_rate

    function automatic logic prp_encoding(input logic [1:0] rate);
        return (rate == `PRP_RATE_8G0) ? `PRP_ENC_128B130B : `PRP_ENC_8B10B;
    endfunction : prp_encoding

endpackage : prp_pkg

// ---- pkg/prp_link_if.sv ----
`timescale 1ns/1ps

interface prp_link_if;
    logic              dn_valid;
    logic              dn_ready;
    prp_pkg::prp_pkt_t dn_pkt;
    logic              up_valid;
    logic              up_ready;
    prp_pkg::prp_pkt_t up_pkt;
    logic              ts_valid;
    logic [4:0]        ts_width;
    logic [1:0]        ts_rate;
    logic              ep_present;
    logic              ep_ts_valid;
    logic [4:0]        ep_width;
    logic [1:0]        ep_rate;
    logic              link_up;
    logic [4:0]        link_width;
    logic [1:0]        link_rate;
    logic              link_enc;
    logic              lane_rev;

    modport root (
        output dn_valid, dn_pkt, up_ready, ts_valid, ts_width, ts_rate,
               link_up, link_width, link_rate, link_enc, lane_rev,
        input  dn_ready, up_valid, up_pkt, ep_present, ep_ts_valid, ep_width, ep_rate
    );
    modport ep (
        input  dn_valid, dn_pkt, up_ready, ts_valid, ts_width, ts_rate,
               link_up, link_width, link_rate, link_enc, lane_rev,
        output dn_ready, up_valid, up_pkt, ep_present, ep_ts_valid, ep_width, ep_rate
    );
endinterface : prp_link_if

// ---- verilog/prp_endpoint.sv ----
`timescale 1ns/1ps
`include "prp_defines.svh"

module prp_endpoint (
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              ce,
    prp_link_if.ep                 lnk,
    input  wire logic              present,
    input  wire logic [4:0]        max_width,
    input  wire logic [1:0]        max_rate,
    output logic                   rx_valid,
    input  wire logic              rx_ready,
    output prp_pkg::prp_pkt_t      rx_pkt,
    input  wire logic              tx_valid,
    output logic                   tx_ready,
    input  wire prp_pkg::prp_pkt_t tx_pkt,
    output logic                   up,
    output logic [4:0]             width,
    output logic [1:0]             rate,
    output logic                   enc
);

    logic       ts_ack_r;
    logic       up_r;
    logic [4:0] width_r;
    logic [1:0] rate_r;

    // ****************
    // training answer
    // ****************
    // RULE_08: offer own width
    assign lnk.ep_present  = present;
    assign lnk.ep_ts_valid = ts_ack_r;
    assign lnk.ep_width    = max_width;
    // RULE_09: offer own rate
    assign lnk.ep_rate     = max_rate;

    always_ff @(posedge clk) begin
        if (reset)
            ts_ack_r <= 1'b0;
        else if (ce)
            ts_ack_r <= lnk.ts_valid && present && !lnk.link_up;
    end

    // RULE_08: adopt negotiated width
    always_ff @(posedge clk) begin
        if (reset) begin
            up_r    <= 1'b0;
            width_r <= `PRP_WID_X1;
            rate_r  <= `PRP_RATE_2G5;
        end else if (ce) begin
            up_r    <= lnk.link_up;
            width_r <= lnk.link_width;
            rate_r  <= lnk.link_rate;
        end
    end

    assign up    = up_r;
    assign width = width_r;
    assign rate  = rate_r;
    // RULE_10: 8b/10b below gen3
    // RULE_11: 128b/130b at gen3
    assign enc   = prp_pkg::prp_encoding(rate_r);

    // ****************
    // packet paths
    // ****************
    // gated until link up
    assign rx_valid     = lnk.dn_valid && up_r;
    assign rx_pkt       = lnk.dn_pkt;
    assign lnk.dn_ready = rx_ready && up_r;
    assign lnk.up_valid = tx_valid && up_r;
    assign lnk.up_pkt   = tx_pkt;
    assign tx_ready     = lnk.up_ready && up_r;

endmodule : prp_endpoint

// ---- verilog/prp_root_port.sv ----
`timescale 1ns/1ps
`include "prp_defines.svh"

// Summary of operation
// RULE_01: downstream addresses keep bits 63:36 zero
// RULE_02: upstream reads above 64 GB get UR
// RULE_03: upstream writes above 64 GB silently dropped
// RULE_04: retry-status configuration completions are reissued
// RULE_05: low 256 config bytes are legacy registers
// RULE_06: 4-KB config block, extended from 100h
// RULE_07: peer traffic: VC0 posted writes only
// RULE_08: width trains x16 down to x1
// RULE_09: rates 2.5, 5.0, 8.0 GT/s negotiated
// RULE_10: 5.0 GT/s uses 8b/10b
// RULE_11: 8.0 GT/s uses 128b/130b
// RULE_12: lane reversal static only, strap
// RULE_13: no hot-plug handling at all
// RULE_14: link trains automatically after reset
// RULE_15: link timed from 100 MHz reference
// RULE_16: above-64 GB test ORs bits 63:36
// RULE_17: configuration reissues bounded by limit

module prp_root_port #(
    parameter int          BUF_DEPTH   = 2,
    parameter logic [7:0]  RETRY_LIMIT = `PRP_RETRY_LIMIT
) (
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              ce,
    prp_link_if.root               lnk,
    input  wire logic [4:0]        max_width,
    input  wire logic [1:0]        max_rate,
    input  wire logic              lane_rev_strap,
    input  wire logic              req_valid,
    output logic                   req_ready,
    input  wire prp_pkg::prp_pkt_t req_pkt,
    input  wire logic              peer_valid,
    output logic                   peer_ready,
    input  wire logic [2:0]        peer_vc,
    input  wire prp_pkg::prp_pkt_t peer_pkt,
    output logic                   peer_drop,
    output logic                   cpl_valid,
    output prp_pkg::prp_pkt_t      cpl_pkt,
    output logic                   fwd_valid,
    output prp_pkg::prp_pkt_t      fwd_pkt,
    output logic                   up_drop
);

    // ****************
    // link training
    // ****************
    prp_pkg::prp_train_t st_r;
    logic [4:0]          width_r;
    logic [1:0]          rate_r;
    logic                lane_rev_r;
    logic                strap_done_r;

    // RULE_14: self-started training
    // RULE_13: no retrain on removal
    always_ff @(posedge clk) begin
        if (reset)
            st_r <= prp_pkg::PRP_DETECT;
        else if (ce) begin
            unique case (st_r)
                prp_pkg::PRP_DETECT: if (lnk.ep_present) st_r <= prp_pkg::PRP_NEGOT;
                prp_pkg::PRP_NEGOT:  if (lnk.ep_ts_valid) st_r <= prp_pkg::PRP_UP;
                prp_pkg::PRP_UP:     st_r <= prp_pkg::PRP_UP;
                default:             st_r <= prp_pkg::PRP_DETECT;
            endcase
        end
    end

    // RULE_08: common width
    // RULE_09: common rate
    always_ff @(posedge clk) begin
        if (reset) begin
            width_r <= `PRP_WID_X1;
            rate_r  <= `PRP_RATE_2G5;
        end else if (ce && st_r == prp_pkg::PRP_NEGOT && lnk.ep_ts_valid) begin
            width_r <= prp_pkg::prp_pick_width(max_width, lnk.ep_width);
            rate_r  <= prp_pkg::prp_pick_rate(max_rate, lnk.ep_rate);
        end
    end

    // RULE_12: strap caught once
    always_ff @(posedge clk) begin
        if (reset) begin
            lane_rev_r   <= 1'b0;
            strap_done_r <= 1'b0;
        end else if (ce && !strap_done_r) begin
            lane_rev_r   <= lane_rev_strap;
            strap_done_r <= 1'b1;
        end
    end

    logic link_up;
    assign link_up        = (st_r == prp_pkg::PRP_UP);
    assign lnk.ts_valid   = (st_r == prp_pkg::PRP_NEGOT);
    assign lnk.ts_width   = max_width;
    assign lnk.ts_rate    = max_rate;
    assign lnk.link_up    = link_up;
    assign lnk.link_width = width_r;
    assign lnk.link_rate  = rate_r;
    // RULE_10: 8b/10b below gen3
    // RULE_11: 128b/130b at gen3
    assign lnk.link_enc   = prp_pkg::prp_encoding(rate_r);
    assign lnk.lane_rev   = lane_rev_r;

    // ****************
    // upstream checks
    // ****************
    logic up_high;
    logic up_is_req;
    logic up_is_cpl;
    logic up_take;
    logic ur_pend_r;
    logic [7:0] ur_tag_r;

    // RULE_16: OR of bits 63:36
    assign up_high   = |lnk.up_pkt.addr[`PRP_ADDR_HI:`PRP_ADDR_LIM_LO];
    assign up_is_req = (lnk.up_pkt.kind == `PRP_KIND_MRD) || (lnk.up_pkt.kind == `PRP_KIND_MWR);
    assign up_is_cpl = (lnk.up_pkt.kind == `PRP_KIND_CPL) || (lnk.up_pkt.kind == `PRP_KIND_CPLD);
    // one pending UR at a time stalls the link
    assign lnk.up_ready = link_up && !ur_pend_r;
    assign up_take      = lnk.up_valid && lnk.up_ready;

    // ****************
    // configuration retry
    // ****************
    logic              cfg_busy_r;
    prp_pkg::prp_pkt_t cfg_hold_r;
    logic [7:0]        retry_cnt_r;
    logic              retry_pend_r;
    logic              cfg_cpl;
    logic              crs_hit;
    logic              do_retry;

    assign cfg_cpl  = up_take && up_is_cpl && cfg_busy_r && (lnk.up_pkt.tag == cfg_hold_r.tag);
    assign crs_hit  = cfg_cpl && (lnk.up_pkt.status == `PRP_ST_CRS);
    // RULE_17: bounded reissue count
    assign do_retry = crs_hit && (retry_cnt_r < RETRY_LIMIT);

    // ****************
    // two-entry downstream buffer
    // ****************
    prp_pkg::prp_pkt_t buf_mem [BUF_DEPTH];
    logic [$clog2(BUF_DEPTH)-1:0] wr_ptr_r;
    logic [$clog2(BUF_DEPTH)-1:0] rd_ptr_r;
    logic [$clog2(BUF_DEPTH):0]   cnt_r;
    logic              buf_in_ready;
    logic              buf_push;
    logic              buf_pop;
    prp_pkg::prp_pkt_t push_pkt;
    logic              sel_retry;
    logic              sel_ur;
    logic              sel_peer;
    logic              sel_req;
    logic              req_is_cfg;
    logic              peer_ok;

    assign buf_in_ready = link_up && (cnt_r != BUF_DEPTH[$clog2(BUF_DEPTH):0]);
    assign buf_pop      = lnk.dn_valid && lnk.dn_ready;
    assign lnk.dn_valid = (cnt_r != '0);
    assign lnk.dn_pkt   = buf_mem[rd_ptr_r];

    assign req_is_cfg = (req_pkt.kind == `PRP_KIND_CFGRD) || (req_pkt.kind == `PRP_KIND_CFGWR);
    // RULE_07: peer posted writes on VC0
    assign peer_ok    = (peer_pkt.kind == `PRP_KIND_MWR) && (peer_vc == 3'h0);

    // fixed priority: retry, UR, peer, fabric
    assign sel_retry  = buf_in_ready && retry_pend_r;
    assign sel_ur     = buf_in_ready && !retry_pend_r && ur_pend_r;
    assign sel_peer   = buf_in_ready && !retry_pend_r && !ur_pend_r && peer_valid && peer_ok;
    assign peer_ready = (buf_in_ready && !retry_pend_r && !ur_pend_r) || !peer_ok;
    assign req_ready  = buf_in_ready && !retry_pend_r && !ur_pend_r && !(peer_valid && peer_ok)
                        && !(req_is_cfg && cfg_busy_r);
    assign sel_req    = req_valid && req_ready;
    assign buf_push   = sel_retry || sel_ur || sel_peer || sel_req;

    always_comb begin
        push_pkt = req_pkt;
        if (sel_retry)
            push_pkt = cfg_hold_r;
        else if (sel_ur) begin
            push_pkt        = '0;
            push_pkt.kind   = `PRP_KIND_CPL;
            push_pkt.tag    = ur_tag_r;
            // RULE_02: UR answer
            push_pkt.status = `PRP_ST_UR;
        end else if (sel_peer)
            push_pkt = peer_pkt;
        // RULE_05: low 256 bytes legacy
        // RULE_06: 4-KB block per function
        push_pkt.legacy = (push_pkt.kind == `PRP_KIND_CFGRD || push_pkt.kind == `PRP_KIND_CFGWR)
                          && (push_pkt.addr[`PRP_CFG_REG_HI:0] < `PRP_CFG_EXT_BASE);
        if (push_pkt.kind == `PRP_KIND_CFGRD || push_pkt.kind == `PRP_KIND_CFGWR)
            push_pkt.addr[`PRP_ADDR_HI:`PRP_CFG_FN_HI+1] = '0;
        // RULE_01: clear bits 63:36
        push_pkt.addr[`PRP_ADDR_HI:`PRP_ADDR_LIM_LO] = '0;
    end

    always_ff @(posedge clk) begin
        if (ce && buf_push)
            buf_mem[wr_ptr_r] <= push_pkt;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            cnt_r    <= '0;
        end else if (ce) begin
            if (buf_push)
                wr_ptr_r <= wr_ptr_r + 1'b1;
            if (buf_pop)
                rd_ptr_r <= rd_ptr_r + 1'b1;
            cnt_r <= cnt_r + {{$clog2(BUF_DEPTH){1'b0}}, buf_push} - {{$clog2(BUF_DEPTH){1'b0}}, buf_pop};
        end
    end

    // RULE_04: hold and reissue
    always_ff @(posedge clk) begin
        if (reset) begin
            cfg_busy_r   <= 1'b0;
            cfg_hold_r   <= '0;
            retry_cnt_r  <= '0;
            retry_pend_r <= 1'b0;
        end else if (ce) begin
            if (sel_req && req_is_cfg) begin
                cfg_busy_r  <= 1'b1;
                cfg_hold_r  <= push_pkt;
                retry_cnt_r <= '0;
            end else if (cfg_cpl && !do_retry)
                cfg_busy_r <= 1'b0;
            if (do_retry) begin
                retry_pend_r <= 1'b1;
                retry_cnt_r  <= retry_cnt_r + 8'h01;
            end else if (sel_retry)
                retry_pend_r <= 1'b0;
        end
    end

    // RULE_02: queue UR for high read
    always_ff @(posedge clk) begin
        if (reset) begin
            ur_pend_r <= 1'b0;
            ur_tag_r  <= '0;
        end else if (ce) begin
            if (up_take && up_high && lnk.up_pkt.kind == `PRP_KIND_MRD) begin
                ur_pend_r <= 1'b1;
                ur_tag_r  <= lnk.up_pkt.tag;
            end else if (sel_ur)
                ur_pend_r <= 1'b0;
        end
    end

    // ****************
    // fabric outputs
    // ****************
    always_ff @(posedge clk) begin
        if (reset) begin
            cpl_valid <= 1'b0;
            cpl_pkt   <= '0;
            fwd_valid <= 1'b0;
            fwd_pkt   <= '0;
            up_drop   <= 1'b0;
            peer_drop <= 1'b0;
        end else if (ce) begin
            // retried completions stay hidden from the fabric
            cpl_valid <= up_take && up_is_cpl && !do_retry;
            cpl_pkt   <= lnk.up_pkt;
            fwd_valid <= up_take && up_is_req && !up_high;
            fwd_pkt   <= lnk.up_pkt;
            // RULE_03: high write dropped
            up_drop   <= up_take && up_high && lnk.up_pkt.kind == `PRP_KIND_MWR;
            // RULE_07: peer reads and non-VC0 writes refused
            peer_drop <= peer_valid && !peer_ok;
        end
    end

    // RULE_15: clk stands for reference
    localparam int REFCLK_MHZ = `PRP_REFCLK_MHZ;

endmodule : prp_root_port

// ---- verif/prp_link_asserts.sv ----
`timescale 1ns/1ps
`include "prp_defines.svh"

module prp_link_asserts (
    input wire logic              clk,
    input wire logic              reset,
    input wire logic              dn_valid,
    input wire logic              dn_ready,
    input wire prp_pkg::prp_pkt_t dn_pkt,
    input wire logic              up_valid,
    input wire logic              up_ready,
    input wire prp_pkg::prp_pkt_t up_pkt,
    input wire logic              ts_valid,
    input wire logic              link_up,
    input wire logic [4:0]        link_width,
    input wire logic [1:0]        link_rate,
    input wire logic              link_enc,
    input wire logic              lane_rev
);
    // ****************
    // link properties
    // ****************
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_dn_addr_clear: assert property (dn_valid |-> dn_pkt.addr[63:36] == 28'h0)
        else $error("downstream address above 64 GB");
    // a stalled word must hold
    a_dn_hold_stall: assert property (dn_valid && !dn_ready |=> dn_valid && $stable(dn_pkt))
        else $error("stalled packet changed");
    a_cfg_legacy_map: assert property (dn_valid && dn_pkt.kind inside {`PRP_KIND_CFGRD, `PRP_KIND_CFGWR}
        |-> dn_pkt.legacy == (dn_pkt.addr[11:0] < `PRP_CFG_EXT_BASE) && dn_pkt.addr[63:28] == 36'h0)
        else $error("config legacy flag wrong");
    a_up_read_ur: assert property (up_valid && up_ready && up_pkt.kind == `PRP_KIND_MRD
        && (|up_pkt.addr[63:36]) |-> ##[1:40] (dn_valid && dn_pkt.kind == `PRP_KIND_CPL
        && dn_pkt.status == `PRP_ST_UR))
        else $error("no UR for high read");
    a_train_auto: assert property ($rose(ts_valid) |-> ##[1:4] link_up)
        else $error("link did not come up");
    a_link_stays_up: assert property (link_up |=> link_up)
        else $error("link dropped");
    a_width_legal: assert property (link_up |-> link_width inside {5'h01, 5'h02, 5'h04, 5'h08, 5'h10})
        else $error("illegal link width");
    a_rate_legal: assert property (link_up |-> link_rate inside {2'h0, 2'h1, 2'h2})
        else $error("illegal link rate");
    a_gen2_enc: assert property (link_up && link_rate == `PRP_RATE_5G0 |-> link_enc == `PRP_ENC_8B10B)
        else $error("wrong encoding at 5.0");
    a_gen3_enc: assert property (link_up && link_rate == `PRP_RATE_8G0 |-> link_enc == `PRP_ENC_128B130B)
        else $error("wrong encoding at 8.0");
    a_lane_rev_static: assert property (link_up |=> $stable(lane_rev))
        else $error("lane order changed");
endmodule : prp_link_asserts

// ---- verif/testbench.sv ----
`timescale 1ns/1ps
`include "prp_defines.svh"

module testbench;
    localparam int RL = 3;
    logic clk, reset, strap, present, req_valid, req_ready, peer_valid, peer_ready, peer_drop, ce;
    logic cpl_valid, fwd_valid, up_drop, rx_valid, rx_ready, tx_valid, tx_ready, up, enc;
    logic [4:0] rw, ew, width;
    logic [1:0] rr, er, rate;
    logic [2:0] peer_vc;
    prp_pkg::prp_pkt_t req_pkt, peer_pkt, cpl_pkt, fwd_pkt, rx_pkt, tx_pkt, lfwd, lcpl;
    prp_pkg::prp_pkt_t rxq[$], eq[$];
    int seed = 25;
    int failures, comparisons, cycles, nf, nc, nd, np;

    // ****************
    // ends and checker
    // ****************
    prp_link_if lnk_if ();
    prp_root_port #(.RETRY_LIMIT(8'(RL))) prp_root_port_inst (.clk(clk), .reset(reset), .ce(ce),
        .lnk(lnk_if.root), .max_width(rw), .max_rate(rr), .lane_rev_strap(strap), .req_valid(req_valid),
        .req_ready(req_ready), .req_pkt(req_pkt), .peer_valid(peer_valid), .peer_ready(peer_ready),
        .peer_vc(peer_vc), .peer_pkt(peer_pkt), .peer_drop(peer_drop), .cpl_valid(cpl_valid),
        .cpl_pkt(cpl_pkt), .fwd_valid(fwd_valid), .fwd_pkt(fwd_pkt), .up_drop(up_drop));
    prp_endpoint prp_endpoint_inst (.clk(clk), .reset(reset), .ce(ce), .lnk(lnk_if.ep), .present(present),
        .max_width(ew), .max_rate(er), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_pkt(rx_pkt),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_pkt(tx_pkt), .up(up), .width(width), .rate(rate), .enc(enc));
    prp_link_asserts prp_link_asserts_inst (.clk(clk), .reset(reset), .dn_valid(lnk_if.dn_valid),
        .dn_ready(lnk_if.dn_ready), .dn_pkt(lnk_if.dn_pkt), .up_valid(lnk_if.up_valid),
        .up_ready(lnk_if.up_ready), .up_pkt(lnk_if.up_pkt), .ts_valid(lnk_if.ts_valid),
        .link_up(lnk_if.link_up), .link_width(lnk_if.link_width), .link_rate(lnk_if.link_rate),
        .link_enc(lnk_if.link_enc), .lane_rev(lnk_if.lane_rev));

    // ****************
    // helpers
    // ****************
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // sample at negedge, where values settle
    always @(negedge clk) begin
        if (rx_valid === 1'b1 && rx_ready === 1'b1) rxq.push_back(rx_pkt);
        if (fwd_valid === 1'b1) begin nf++; lfwd = fwd_pkt; end
        if (cpl_valid === 1'b1) begin nc++; lcpl = cpl_pkt; end
        if (up_drop === 1'b1) nd++;
        if (peer_drop === 1'b1) np++;
    end

    // stall one cycle in four to fill the buffer
    always @(posedge clk) begin
        rx_ready <= ($random(seed) % 4) != 0;
        cycles++;
        if (cycles == 20000) begin
            failures++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [127:0] g, input logic [127:0] e);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk

    task automatic send(input int sel, input prp_pkg::prp_pkt_t p);
        int i;
        @(posedge clk);
        case (sel)
            0: begin req_valid <= 1'b1; req_pkt <= p; end
            1: begin peer_valid <= 1'b1; peer_pkt <= p; end
            default: begin tx_valid <= 1'b1; tx_pkt <= p; end
        endcase
        for (i = 0; i < 200; i++) begin
            @(negedge clk);
            if (((sel == 0) ? req_ready : (sel == 1) ? peer_ready : tx_ready) === 1'b1) break;
        end
        @(posedge clk);
        req_valid <= 1'b0;
        peer_valid <= 1'b0;
        tx_valid <= 1'b0;
    endtask : send

    task automatic get_rx(output prp_pkg::prp_pkt_t g);
        int i;
        for (i = 0; i < 300 && rxq.size() == 0; i++) @(negedge clk);
        g = (rxq.size() > 0) ? rxq.pop_front() : '1;
    endtask : get_rx

    function automatic prp_pkg::prp_pkt_t mk(input logic [2:0] k, input logic [63:0] a, input logic [7:0] t,
                                              input logic [2:0] s);
        mk = '{kind: k, addr: a, data: 32'(a ^ 64'h5A5A), tag: t, status: s, legacy: 1'b0};
    endfunction : mk

    function automatic prp_pkg::prp_pkt_t exp_dn(input prp_pkg::prp_pkt_t p);
        exp_dn = p;
        exp_dn.addr[63:36] = 28'h0;
        if (p.kind == `PRP_KIND_CFGRD || p.kind == `PRP_KIND_CFGWR) begin
            exp_dn.addr[63:28] = 36'h0;
            exp_dn.legacy = p.addr[11:0] < `PRP_CFG_EXT_BASE;
        end
    endfunction : exp_dn

    function automatic logic [4:0] exp_w(input logic [4:0] a, input logic [4:0] b);
        logic [4:0] m;
        m = (a < b) ? a : b;
        for (exp_w = 5'h10; exp_w > m; exp_w = exp_w >> 1) begin
        end
    endfunction : exp_w

    // ****************
    // main sequence
    // ****************
    initial begin
        prp_pkg::prp_pkt_t p, q;
        int i, j, k, f, d;
        logic [1:0] xr;
        {reset, present, strap, req_valid, peer_valid, tx_valid, ce} = 7'h61;
        {rw, ew, rr, er, peer_vc} = 17'h0;
        {req_pkt, peer_pkt, tx_pkt} = '0;
        for (i = 0; i < 6; i++) begin
            @(posedge clk);
            reset <= 1'b1;
            rw <= (i == 0) ? 5'h10 : 5'(1 + {$random(seed)} % 16);
            ew <= (i == 0) ? 5'h10 : 5'(1 + {$random(seed)} % 16);
            rr <= 2'(i % 3);
            er <= (i == 0) ? 2'h2 : 2'({$random(seed)} % 3);
            strap <= i[0];
            repeat (5) @(posedge clk);
            reset <= 1'b0;
            for (j = 0; j < 30 && up !== 1'b1; j++) @(negedge clk);
            @(negedge clk);
            xr = (rr < er) ? rr : er;
            chk(128'(up), 128'(1));
            chk(128'({lnk_if.link_width, width}), 128'({2{exp_w(rw, ew)}}));
            chk(128'({lnk_if.link_rate, rate}), 128'({xr, xr}));
            chk(128'({lnk_if.link_enc, enc}), 128'({2{xr == 2'h2}}));
            chk(128'(lnk_if.lane_rev), 128'(strap));
            $display("test training %0d done", i);
        end
        for (i = 0; i < 20; i++) begin
            p = mk(i[0] ? `PRP_KIND_MWR : `PRP_KIND_MRD, (i < 2) ? '1 : {$random(seed), $random(seed)}, 8'(i), 3'h0);
            eq.push_back(exp_dn(p));
            send(0, p);
        end
        for (i = 0; i < 20; i++) begin
            get_rx(q);
            chk(128'(q), 128'(eq.pop_front()));
        end
        $display("test downstream done");
        for (i = 0; i < 4; i++) begin
            p = mk(i[0] ? `PRP_KIND_CFGWR : `PRP_KIND_CFGRD, {$random(seed), $random(seed)}, 8'(40 + i), 3'h0);
            p.addr[11:0] = (i == 0) ? 12'h0FF : (i == 1) ? 12'h100 : (i == 2) ? 12'h000 : 12'hFFF;
            send(0, p);
            get_rx(q);
            chk(128'(q), 128'(exp_dn(p)));
            k = nc;
            send(2, mk(`PRP_KIND_CPL, 64'h0, p.tag, `PRP_ST_SC));
            repeat (2) @(negedge clk);
            chk(128'({nc, lcpl.tag}), 128'({k + 1, p.tag}));
        end
        $display("test config space done");
        p = mk(`PRP_KIND_CFGRD, 64'h0000_0000_0ABC_D123, 8'h77, 3'h0);
        send(0, p);
        get_rx(q);
        f = nc;
        k = 0;
        for (j = 0; j < 10 && nc == f; j++) begin
            send(2, mk(`PRP_KIND_CPL, 64'h0, p.tag, `PRP_ST_CRS));
            for (i = 0; i < 50 && rxq.size() == 0 && nc == f; i++) @(negedge clk);
            if (rxq.size() > 0) begin
                get_rx(q);
                chk(128'(q), 128'(exp_dn(p)));
                k++;
            end
        end
        chk(128'({k, lcpl.status}), 128'({RL, `PRP_ST_CRS}));
        $display("test retry done");
        for (i = 0; i < 8; i++) begin
            p = mk(i[0] ? `PRP_KIND_MWR : `PRP_KIND_MRD, {28'h0, 4'($random(seed)), $random(seed)}, 8'(80 + i), 3'h0);
            if (i[1]) p.addr[36 + {$random(seed)} % 28] = 1'b1;
            {f, d} = {nf, nd};
            send(2, p);
            repeat (2) @(negedge clk);
            if (!i[1]) begin
                chk(128'({nf, lfwd}), 128'({f + 1, p}));
            end else if (!i[0]) begin
                get_rx(q);
                chk(128'({q.kind, q.status, q.tag, nf}), 128'({`PRP_KIND_CPL, `PRP_ST_UR, p.tag, f}));
            end else begin
                chk(128'({nd, nf}), 128'({d + 1, f}));
            end
        end
        $display("test upstream limit done");
        for (i = 0; i < 9; i++) begin
            @(posedge clk);
            peer_vc <= 3'(i);
            p = mk((i == 8) ? `PRP_KIND_MRD : `PRP_KIND_MWR, {$random(seed), $random(seed)}, 8'(90 + i), 3'h0);
            d = np;
            send(1, p);
            repeat (2) @(negedge clk);
            if (i == 0) begin
                get_rx(q);
                chk(128'(q), 128'(exp_dn(p)));
            end else begin
                chk(128'(np), 128'(d + 1));
            end
        end
        $display("test peer done");
        @(posedge clk);
        present <= 1'b0;
        repeat (10) @(negedge clk);
        chk(128'(lnk_if.link_up), 128'(1));
        @(posedge clk);
        ce <= 1'b0;
        d = np;
        send(1, p);
        repeat (2) @(negedge clk);
        chk(128'(np), 128'(d));
        $display("test removal done");
        print_verdict();
    end
endmodule : testbench
